/* shared/clock_gen_defs.vh */
`ifndef CLOCK_GEN_DEFS_VH
`define CLOCK_GEN_DEFS_VH
// word addresses of the registers
`define ADDR_STATUS_MAIN   4'h0
`define ADDR_STATUS_OSC    4'h1
`define ADDR_FILTER_UPPER  4'h2
`define ADDR_FILTER_LOWER  4'h3
`define ADDR_TRIM          4'h4
`define ADDR_CONTROL       4'h5
// word index width (address is word address)
`define ADDR_W             4
// status main field positions
`define ST_MODE_HI         7
`define ST_MODE_LO         6
`define ST_REF             5
`define ST_LOL             4
`define ST_LOCK            3
`define ST_LOC             2
`define ST_EXT_REF_STABLE            1
`define ST_IRQ             0
// control register field positions
`define CTL_MODE_HI        1
`define CTL_MODE_LO        0
`define CTL_LOSS_OF_CLOCK_RESET_ENABLE          2
`define CTL_LOSS_OF_LOCK_RESET_ENABLE          3
// clock modes
`define MODE_SELF          2'h0
`define MODE_FEI           2'h1
`define MODE_FBE           2'h2
`define MODE_FEE           2'h3
// reset values
`define FILTER_RESET       12'h000
`define TRIM_RESET         8'h80
// synchroniser stages for the mode request crossing
`define MODE_SYNC_STAGES   2
`endif

/* src/clock_gen_status_filter_trim.v */
// Behaviour
// - mode status at bits 7:6, four encodings
// - mode status follows select after synchronisation and, for engaged modes, osc stable; held while off
// - bit 5 shows selected reference source
// - loss-of-lock flag sticky until cleared
// - loss-of-lock raises interrupt or reset request
// - lock bit forced low outside engaged modes
// - loss-of-clock flag sticky until cleared
// - loss-of-clock raises interrupt or reset request
// - bit 1 shows external reference stable
// - irq flag set while request pending
// - new event restarts the clear sequence
// - writing zero leaves irq flag alone
// - osc stable after two steady samples
// - leaving off waits osc stable first only when an engaged mode is selected
// - self-clocked monitoring starts after osc stable
// - osc stable cleared on entering off
// - filter writable only with select self-clocked
// - upper write updates whole 12-bit filter
// - upper write ignored while latch incomplete
// - lower register shows filter bits 7:0
// - trim adjusts reference period about 25 percent
// - trim binary weighted, larger lengthens period
`timescale 1ns/1ps
`include "clock_gen_defs.vh"

module clock_gen_status_filter_trim (
  input  wire        sys_clk,
  input  wire        rst_n,
  input  wire [3:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        refIsCrystal,
  input  wire        lockAcquired,
  input  wire        lockLostEvent,
  input  wire        clockLostEvent,
  input  wire        extRefStableIn,
  input  wire        oscClockToggling,
  input  wire        countErrorInTol,
  input  wire        sampleStrobe,
  input  wire        offMode,
  output reg  [11:0] loopFilterValue,
  output reg  [7:0]  referenceTrim,
  output reg  [1:0]  clockModeSelect,
  output reg         clockGenIrq,
  output reg         clockGenResetReq,
  output reg         oscMonitorEnable,
  output reg         leaveOffAllowed
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: pins from other domains pass two flops
  reg  [6:0] syncA_q;
  reg  [6:0] syncB_q;
  reg  [6:0] syncPrev_q;
  wire       refSel      = syncB_q[0];
  wire       lockIn      = syncB_q[1];
  wire       lolEvt      = syncB_q[2] & ~syncPrev_q[2];
  wire       locEvt      = syncB_q[3] & ~syncPrev_q[3];
  wire       ercsIn      = syncB_q[4];
  wire       oscToggling = syncB_q[5];
  wire       offIn       = syncB_q[6];
  wire       offEnter    = offIn & ~syncPrev_q[6];

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      syncA_q    <= 7'h00;
      syncB_q    <= 7'h00;
      syncPrev_q <= 7'h00;
    end else begin
      syncA_q    <= {offMode, oscClockToggling, extRefStableIn, clockLostEvent,
                     lockLostEvent, lockAcquired, refIsCrystal};
      syncB_q    <= syncA_q;
      syncPrev_q <= syncB_q;
    end
  end

  // the tolerance comparison and its strobe come from the lock detector on sys_clk
  ////////////////////////////////////////////////////////////////////////////
  // bus decode
  wire       acc     = (read | write) & waitrequest;
  // writes and read side effects commit at the edge the master sees waitrequest low
  wire       wrStrb  = write & ~waitrequest;
  wire       rdStrb  = read & waitrequest;
  wire       rdDone  = read & ~waitrequest;
  wire [7:0] wdata   = writedata[7:0];

  reg  [1:0] ctlMode_q;
  reg        loss_of_clock_reset_enable_q;
  reg        loss_of_lock_reset_enable_q;
  reg  [1:0] modeSync_q [0:`MODE_SYNC_STAGES-1];
  reg  [1:0] modeStatus_q;
  reg        lolFlag_q;
  reg        locFlag_q;
  reg        lockBit_q;
  reg        ext_ref_stable_q;
  reg        irqFlag_q;
  reg        clearArmed_q;
  reg        oscStable_q;
  reg  [1:0] steadyCnt_q;
  reg  [7:0] lowerStage_q;
  reg        latchBusy_q;
  reg  [11:0] latchVal_q;

  function engagedMode;
    input [1:0] m;
    begin
      engagedMode = (m == `MODE_FEI) || (m == `MODE_FEE);
    end
  endfunction

  wire [7:0] statusMain = {modeStatus_q, refSel, lolFlag_q, lockBit_q,
                           locFlag_q, ext_ref_stable_q, irqFlag_q};
  wire       filterWrOk = (ctlMode_q == `MODE_SELF);
  wire       irqEvt     = (lolEvt & ~loss_of_lock_reset_enable_q) | (locEvt & ~loss_of_clock_reset_enable_q);

  ////////////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on second cycle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h00000000;
    end else begin
      if (acc) begin
        waitrequest <= 1'b0;
      end else begin
        waitrequest <= 1'b1;
      end
      if (rdStrb) begin
        if (address == `ADDR_STATUS_MAIN) begin
          readdata <= {24'h000000, statusMain};
        end else if (address == `ADDR_STATUS_OSC) begin
          readdata <= {31'h00000000, oscStable_q};
        end else if (address == `ADDR_FILTER_UPPER) begin
          readdata <= {28'h0000000, loopFilterValue[11:8]};
        end else if (address == `ADDR_FILTER_LOWER) begin
          readdata <= {24'h000000, loopFilterValue[7:0]};
        end else if (address == `ADDR_TRIM) begin
          readdata <= {24'h000000, referenceTrim};
        end else if (address == `ADDR_CONTROL) begin
          readdata <= {28'h0000000, loss_of_lock_reset_enable_q, loss_of_clock_reset_enable_q, ctlMode_q};
        end else begin
          readdata <= 32'h00000000;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control, mode crossing and status flags
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctlMode_q     <= `MODE_SELF;
      loss_of_clock_reset_enable_q       <= 1'b0;
      loss_of_lock_reset_enable_q       <= 1'b0;
      modeSync_q[0] <= `MODE_SELF;
      modeSync_q[1] <= `MODE_SELF;
      modeStatus_q  <= `MODE_SELF;
      lolFlag_q     <= 1'b0;
      locFlag_q     <= 1'b0;
      lockBit_q     <= 1'b0;
      ext_ref_stable_q        <= 1'b0;
      irqFlag_q     <= 1'b0;
      clearArmed_q  <= 1'b0;
      clockGenIrq   <= 1'b0;
      clockGenResetReq <= 1'b0;
      clockModeSelect  <= `MODE_SELF;
    end else begin
      if (wrStrb && address == `ADDR_CONTROL) begin
        ctlMode_q <= wdata[`CTL_MODE_HI:`CTL_MODE_LO];
        loss_of_clock_reset_enable_q   <= wdata[`CTL_LOSS_OF_CLOCK_RESET_ENABLE];
        loss_of_lock_reset_enable_q   <= wdata[`CTL_LOSS_OF_LOCK_RESET_ENABLE];
      end
      clockModeSelect <= ctlMode_q;
      // request passes a crossing before it shows in status
      modeSync_q[0] <= ctlMode_q;
      modeSync_q[1] <= modeSync_q[0];
      if (offIn) begin
        modeStatus_q <= modeStatus_q;
      end else if (engagedMode(modeSync_q[1]) && !oscStable_q) begin
        modeStatus_q <= `MODE_SELF;
      end else begin
        modeStatus_q <= modeSync_q[1];
      end
      lockBit_q <= lockIn & ~offIn & engagedMode(modeStatus_q);
      ext_ref_stable_q    <= ercsIn;
      // sticky flags: event wins over a clearing write
      if (lolEvt) begin
        lolFlag_q <= 1'b1;
      end else if (wrStrb && address == `ADDR_STATUS_MAIN && wdata[`ST_LOL]) begin
        lolFlag_q <= 1'b0;
      end
      if (locEvt) begin
        locFlag_q <= 1'b1;
      end else if (wrStrb && address == `ADDR_STATUS_MAIN && wdata[`ST_LOC]) begin
        locFlag_q <= 1'b0;
      end
      // irq flag: read-with-flag arms, write-one clears, new event disarms
      if (irqEvt) begin
        irqFlag_q    <= 1'b1;
        clearArmed_q <= 1'b0;
      end else if (rdDone && address == `ADDR_STATUS_MAIN && irqFlag_q) begin
        clearArmed_q <= 1'b1;
      end else if (wrStrb && address == `ADDR_STATUS_MAIN && wdata[`ST_IRQ]
                   && clearArmed_q) begin
        irqFlag_q    <= 1'b0;
        clearArmed_q <= 1'b0;
      end
      clockGenIrq      <= irqFlag_q;
      clockGenResetReq <= (lolEvt & loss_of_lock_reset_enable_q) | (locEvt & loss_of_clock_reset_enable_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // oscillator stability
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      oscStable_q      <= 1'b0;
      steadyCnt_q      <= 2'h0;
      oscMonitorEnable <= 1'b0;
      leaveOffAllowed  <= 1'b0;
    end else begin
      if (offEnter || !oscToggling) begin
        oscStable_q <= 1'b0;
        steadyCnt_q <= 2'h0;
      end else if (sampleStrobe) begin
        if (!countErrorInTol) begin
          steadyCnt_q <= 2'h0;
        end else if (steadyCnt_q != 2'h2) begin
          steadyCnt_q <= steadyCnt_q + 2'h1;
        end
        if (countErrorInTol && steadyCnt_q != 2'h0) begin
          oscStable_q <= 1'b1;
        end
      end
      oscMonitorEnable <= oscStable_q && (modeStatus_q == `MODE_SELF);
      leaveOffAllowed  <= ~engagedMode(ctlMode_q) | oscStable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop filter and trim; latch sequence takes one extra cycle to settle
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      loopFilterValue <= `FILTER_RESET;
      lowerStage_q    <= 8'h00;
      latchBusy_q     <= 1'b0;
      latchVal_q      <= `FILTER_RESET;
      referenceTrim   <= `TRIM_RESET;
    end else begin
      if (wrStrb && address == `ADDR_FILTER_LOWER && filterWrOk) begin
        lowerStage_q <= wdata;
      end
      if (latchBusy_q) begin
        loopFilterValue <= latchVal_q;
        latchBusy_q     <= 1'b0;
      end else if (wrStrb && address == `ADDR_FILTER_UPPER && filterWrOk) begin
        latchVal_q  <= {wdata[3:0], lowerStage_q};
        latchBusy_q <= 1'b1;
      end
      // trim drives the reference period directly, plain binary weight
      if (wrStrb && address == `ADDR_TRIM) begin
        referenceTrim <= wdata;
      end
    end
  end

endmodule

/* testbench/clock_gen_monitor.sv */
`timescale 1ns/1ps
module clock_gen_monitor (
  input wire        sys_clk,
  input wire        rst_n,
  input wire [3:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  input wire [11:0] loopFilterValue,
  input wire [7:0]  referenceTrim,
  input wire [1:0]  clockModeSelect,
  input wire        clockGenIrq,
  input wire        clockGenResetReq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // bus answer comes after exactly one wait cycle
  wait_one_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus answer missing after one wait");
  wait_pulse_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  rd_ext_a: assert property (read && !waitrequest |-> readdata[31:8] == 24'h000000)
    else $error("read data not zero extended");
  unmap_rd_a: assert property (read && !waitrequest && address > 4'h5 |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  trim_rd_a: assert property (read && !waitrequest && address == 4'h4 |->
    readdata[7:0] == referenceTrim) else $error("trim read differs from trim output");
  flt_low_a: assert property (read && !waitrequest && address == 4'h3 |->
    readdata[7:0] == loopFilterValue[7:0]) else $error("lower filter read wrong");
  flt_up_a: assert property (read && !waitrequest && address == 4'h2 |->
    readdata[3:0] == loopFilterValue[11:8]) else $error("upper filter read wrong");
  // checked over three cycles so a late latch is also caught
  flt_lock_a: assert property (write && !waitrequest && address == 4'h2 &&
    clockModeSelect != 2'h0 |=> $stable(loopFilterValue) [*3])
    else $error("filter changed outside self-clocked mode");
  irq_hold_a: assert property (write && !waitrequest && address == 4'h0 &&
    !writedata[0] && clockGenIrq |=> clockGenIrq) else $error("zero write cleared irq");
  flt_wr_c: cover property (write && !waitrequest && address == 4'h2 && clockModeSelect == 2'h0);
  irq_clr_c: cover property ($fell(clockGenIrq));
  rst_req_c: cover property (clockGenResetReq);
endmodule
bind clock_gen_status_filter_trim clock_gen_monitor u_mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
  .waitrequest(waitrequest), .loopFilterValue(loopFilterValue), .referenceTrim(referenceTrim),
  .clockModeSelect(clockModeSelect), .clockGenIrq(clockGenIrq),
  .clockGenResetReq(clockGenResetReq));

/* testbench/tb.sv */
`timescale 1ns/1ps
`include "clock_gen_defs.vh"
`define CHK(n, e, v) begin check_count++; if ((v) !== (e)) begin err_total++; \
  $display("MISMATCH %s expected %h seen %h", n, e, v); end end
module tb;
  reg         sys_clk = 0, rst_n = 0, read = 0, write = 0, seenReq = 0;
  reg  [3:0]  address = 0;
  reg  [31:0] writedata = 0;
  reg         refIsCrystal = 0, lockAcquired = 0, lockLostEvent = 0, clockLostEvent = 0;
  reg         extRefStableIn = 0, oscClockToggling = 0, countErrorInTol = 0;
  reg         sampleStrobe = 0, offMode = 0;
  reg  [7:0]  rd;
  wire [31:0] readdata;
  wire [11:0] loopFilterValue;
  wire [7:0]  referenceTrim;
  wire [1:0]  clockModeSelect;
  wire        waitrequest, clockGenIrq, clockGenResetReq, oscMonitorEnable, leaveOffAllowed;
  integer     err_total = 0, check_count = 0, cyc = 0, k;
  clock_gen_status_filter_trim uut (.sys_clk(sys_clk), .rst_n(rst_n), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .refIsCrystal(refIsCrystal), .lockAcquired(lockAcquired),
    .lockLostEvent(lockLostEvent), .clockLostEvent(clockLostEvent),
    .extRefStableIn(extRefStableIn), .oscClockToggling(oscClockToggling),
    .countErrorInTol(countErrorInTol), .sampleStrobe(sampleStrobe), .offMode(offMode),
    .loopFilterValue(loopFilterValue), .referenceTrim(referenceTrim),
    .clockModeSelect(clockModeSelect), .clockGenIrq(clockGenIrq),
    .clockGenResetReq(clockGenResetReq), .oscMonitorEnable(oscMonitorEnable),
    .leaveOffAllowed(leaveOffAllowed));
  initial forever #4 sys_clk = ~sys_clk;
  // reset request is a one-cycle pulse, so it is caught here rather than polled
  always @(posedge sys_clk) begin
    if (clockGenResetReq === 1'h1) seenReq <= 1'h1;
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total++;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (err_total == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task acc(input w, input [3:0] a, input [7:0] d);
    begin
      @(posedge sys_clk);
      read <= !w;
      write <= w;
      address <= a;
      writedata <= {24'h000000, d};
      @(posedge sys_clk);
      while (waitrequest !== 1'h0) @(posedge sys_clk);
      rd = readdata[7:0];
      read <= 1'h0;
      write <= 1'h0;
    end
  endtask
  task wr(input [3:0] a, input [7:0] d);
    acc(1'h1, a, d);
  endtask
  task rdchk(input [3:0] a, input [7:0] m, input [7:0] e);
    begin
      acc(1'h0, a, 8'h00);
      `CHK($sformatf("register %h", a), e, rd & m)
    end
  endtask
  task wt(input integer c);
    repeat (c) @(posedge sys_clk);
  endtask
  // events are held a few cycles so the input synchroniser sees the edge
  task ev(input lol);
    begin
      if (lol) lockLostEvent <= 1'h1;
      else clockLostEvent <= 1'h1;
      wt(4);
      lockLostEvent <= 1'h0;
      clockLostEvent <= 1'h0;
      wt(6);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(3);
    rst_n <= 1'h1;
    `CHK("referenceTrim", 8'h80, referenceTrim)
    `CHK("loopFilterValue", 12'h000, loopFilterValue)
    wr(`ADDR_TRIM, 8'h3C);
    rdchk(`ADDR_TRIM, 8'hFF, 8'h3C);
    wr(`ADDR_FILTER_LOWER, 8'hA5);
    rdchk(`ADDR_FILTER_LOWER, 8'hFF, 8'h00);
    wr(`ADDR_FILTER_UPPER, 8'hF7);
    wt(2);
    `CHK("loopFilterValue", 12'h7A5, loopFilterValue)
    rdchk(`ADDR_FILTER_LOWER, 8'hFF, 8'hA5);
    wr(`ADDR_CONTROL, 8'h01);
    wr(`ADDR_FILTER_UPPER, 8'h03);
    wt(3);
    `CHK("loopFilterValue", 12'h7A5, loopFilterValue)
    rdchk(`ADDR_STATUS_MAIN, 8'hC0, 8'h00);
    `CHK("leaveOffAllowed", 1'h0, leaveOffAllowed)
    oscClockToggling <= 1'h1;
    countErrorInTol <= 1'h1;
    wt(3);
    for (k = 0; k < 2; k++) begin
      sampleStrobe <= 1'h1;
      wt(1);
      sampleStrobe <= 1'h0;
      wt(1);
    end
    wt(3);
    rdchk(`ADDR_STATUS_OSC, 8'h01, 8'h01);
    wt(6);
    rdchk(`ADDR_STATUS_MAIN, 8'hC0, 8'h40);
    `CHK("leaveOffAllowed", 1'h1, leaveOffAllowed)
    `CHK("oscMonitorEnable", 1'h0, oscMonitorEnable)
    wr(`ADDR_CONTROL, 8'h00);
    wt(6);
    `CHK("oscMonitorEnable", 1'h1, oscMonitorEnable)
    extRefStableIn <= 1'h1;
    refIsCrystal <= 1'h1;
    lockAcquired <= 1'h1;
    wr(`ADDR_CONTROL, 8'h03);
    wt(6);
    rdchk(`ADDR_STATUS_MAIN, 8'hEA, 8'hEA);
    wr(`ADDR_CONTROL, 8'h02);
    wt(6);
    rdchk(`ADDR_STATUS_MAIN, 8'hC8, 8'h80);
    wr(`ADDR_CONTROL, 8'h03);
    ev(1'h1);
    rdchk(`ADDR_STATUS_MAIN, 8'h11, 8'h11);
    wr(`ADDR_STATUS_MAIN, 8'h00);
    `CHK("clockGenIrq", 1'h1, clockGenIrq)
    rdchk(`ADDR_STATUS_MAIN, 8'h01, 8'h01);
    ev(1'h0);
    wr(`ADDR_STATUS_MAIN, 8'h01);
    `CHK("clockGenIrq", 1'h1, clockGenIrq)
    rdchk(`ADDR_STATUS_MAIN, 8'h15, 8'h15);
    wr(`ADDR_STATUS_MAIN, 8'h15);
    wt(2);
    `CHK("clockGenIrq", 1'h0, clockGenIrq)
    wr(`ADDR_CONTROL, 8'h0F);
    for (k = 0; k < 2; k++) begin
      seenReq <= 1'h0;
      ev(k[0]);
      `CHK("clockGenResetReq", 1'h1, seenReq)
    end
    offMode <= 1'h1;
    wt(4);
    rdchk(`ADDR_STATUS_OSC, 8'h01, 8'h00);
    offMode <= 1'h0;
    rdchk(4'hF, 8'hFF, 8'h00);
    stop_test;
  end
endmodule
